// [logic/pwm_prot.sv]
// Fault, current-limit, blanking and trigger logic of one PWM generator.
// Assumes all inputs synchronous to clk except the trip sources, which
// are synchronised here; cycle_start marks each new PWM cycle.
//
// Behaviour
// - Limit source chosen by four-bit selector
// - Limit polarity bit one means active low
// - Limit acts only while limit enabled
// - Trip source chosen by same code set
// - Trip polarity bit one means active low
// - Mode zero latches trip override
// - Mode one overrides trip cycle by cycle
// - Mode three ignores trip; two reserved
// - Time base match fires trigger pulse
// - Zero compare value gives no trigger
// - Enabled output edges start blanking counter
// - Trip blanking enable masks trip input
// - Limit blanking enable masks limit input
// - Blanking interval in eight-nanosecond steps
// - Unimplemented bits read zero, ignore writes
// - Trip drives outputs from trip overrides
// - Limit drives outputs from limit overrides
// - Cycle override held until next cycle
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_prot_regs.svh"

module pwm_prot import pwm_prot_pkg::*; #(
    parameter int BLANK_CNT_W = 8,
    parameter int TB_W = 16
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire reg_req_t reg_req,
    output logic [15:0] rdata,
    input wire trip_sources_t sources,
    input wire logic gen_high_in,
    input wire logic gen_low_in,
    input wire logic [TB_W-1:0] time_base,
    input wire logic cycle_start,
    input wire logic module_enable,
    output logic gen_high_output,
    output logic gen_low_output,
    output logic trigger_pulse
);

    // Registers
    logic [15:0] fault_current_limit_control_q;
    logic [15:0] trigger_compare_value_q;
    logic [15:0] edge_blanking_control_q;
    logic [15:0] override_values_q;
    logic [15:0] rdata_q;

    // Synchroniser and state
    trip_sources_t sync1_q;
    trip_sources_t sync2_q;
    logic high_prev_q;
    logic low_prev_q;
    logic trip_latched_q;
    logic trip_cycle_q;
    logic limit_cycle_q;
    logic match_prev_q;
    logic gen_high_q;
    logic gen_low_q;
    logic trigger_q;

    // Combinational
    logic [3:0] limit_source_select;
    logic limit_input_polarity;
    logic limit_function_enable;
    logic [3:0] trip_source_select;
    logic trip_input_polarity;
    logic [1:0] trip_response_mode;
    logic trip_mode_on;
    logic [6:0] blanking_interval;
    logic blank_start;
    logic blanking;
    logic limit_raw;
    logic trip_raw;
    logic limit_act;
    logic trip_act;
    logic limit_on;
    logic trip_on;
    logic trig_match;
    logic [15:0] status;
    drive_sel_t drive_sel;

    // Picks one source and applies its polarity; reserved codes stay
    // inactive whatever the polarity, so a stray code never trips
    function automatic logic src_pick(trip_sources_t s, logic [3:0] code,
        logic pol);
        logic r;
        r = 1'b0;
        if (code[3:2] == `SRC_GRP_CMP) begin
            r = s.cmp[code[1:0]] ^ pol;
        end else if (code[3:2] == `SRC_GRP_SHARED) begin
            r = s.shared[code[1:0]] ^ pol;
        end else if (code == `SRC_OWN_TWO) begin
            r = s.own_trip_two ^ pol;
        end else if (code == `SRC_OWN_FOUR) begin
            r = s.own_trip_four ^ pol;
        end
        return r;
    endfunction

    // Blanking steps to clock cycles, rounded up
    function automatic logic [BLANK_CNT_W-1:0] blank_cycles(logic [6:0] v);
        int t;
        t = (int'(v) * `BLANK_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
        return BLANK_CNT_W'(t);
    endfunction

    // Control fields
    assign limit_source_select =
        fault_current_limit_control_q[`LIM_SRC_HI:`LIM_SRC_LO];
    assign limit_input_polarity =
        fault_current_limit_control_q[`LIM_POL_BIT];
    assign limit_function_enable =
        fault_current_limit_control_q[`LIM_EN_BIT];
    assign trip_source_select =
        fault_current_limit_control_q[`TRIP_SRC_HI:`TRIP_SRC_LO];
    assign trip_input_polarity =
        fault_current_limit_control_q[`TRIP_POL_BIT];
    assign trip_response_mode =
        fault_current_limit_control_q[`TRIP_MODE_HI:`TRIP_MODE_LO];
    assign blanking_interval =
        edge_blanking_control_q[`BLANK_HI:`BLANK_LO];
    // Reserved mode code is treated like the disabled one
    assign trip_mode_on = (trip_response_mode == `TRIP_LATCHED) ||
                          (trip_response_mode == `TRIP_CYCLE);

    // Register writes keep only implemented bits
    always_ff @(posedge clk) begin
        if (srst) begin
            fault_current_limit_control_q <= `RST_VAL;
            trigger_compare_value_q <= `RST_VAL;
            edge_blanking_control_q <= `RST_VAL;
            override_values_q <= `RST_VAL;
        end else if (ce && reg_req.wr) begin
            unique case (reg_req.addr)
                `IDX_LIMIT_TRIP_CTRL: fault_current_limit_control_q <=
                    reg_req.wdata & `MASK_LIMIT_TRIP;
                `IDX_TRIG_CMP: trigger_compare_value_q <=
                    reg_req.wdata & `MASK_TRIG;
                `IDX_BLANK_CTRL: edge_blanking_control_q <=
                    reg_req.wdata & `MASK_BLANK;
                `IDX_OVERRIDE: override_values_q <=
                    reg_req.wdata & `MASK_OVERRIDE;
                default: ;
            endcase
        end
    end

    // Status view of the block's own state
    always_comb begin
        status = `READ_ZERO;
        status[`ST_TRIP_LATCHED] = trip_latched_q;
        status[`ST_TRIP_CYCLE] = trip_cycle_q;
        status[`ST_LIMIT_CYCLE] = limit_cycle_q;
        status[`ST_BLANKING] = blanking;
        status[`ST_TRIP_ACTIVE] = trip_act;
        status[`ST_LIMIT_ACTIVE] = limit_act;
    end

    // Read data stands one cycle after the strobe, zero otherwise
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_q <= `READ_ZERO;
        end else if (ce) begin
            rdata_q <= `READ_ZERO;
            if (reg_req.rd) begin
                unique case (reg_req.addr)
                    `IDX_LIMIT_TRIP_CTRL: rdata_q <=
                        fault_current_limit_control_q;
                    `IDX_TRIG_CMP: rdata_q <= trigger_compare_value_q;
                    `IDX_BLANK_CTRL: rdata_q <= edge_blanking_control_q;
                    `IDX_OVERRIDE: rdata_q <= override_values_q;
                    `IDX_STATUS: rdata_q <= status;
                    default: rdata_q <= `READ_ZERO;
                endcase
            end
        end
    end

    // Two-stage synchroniser on all trip and limit sources
    always_ff @(posedge clk) begin
        if (srst) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else if (ce) begin
            sync1_q <= sources;
            sync2_q <= sync1_q;
        end
    end

    // Previous generator levels for edge detection
    always_ff @(posedge clk) begin
        if (srst) begin
            high_prev_q <= 1'b0;
            low_prev_q <= 1'b0;
        end else if (ce) begin
            high_prev_q <= gen_high_in;
            low_prev_q <= gen_low_in;
        end
    end

    // Enabled generator edges restart the blanking interval
    assign blank_start =
        (edge_blanking_control_q[`HIGH_RISE_BIT] &&
         gen_high_in && !high_prev_q) ||
        (edge_blanking_control_q[`HIGH_FALL_BIT] &&
         !gen_high_in && high_prev_q) ||
        (edge_blanking_control_q[`LOW_RISE_BIT] &&
         gen_low_in && !low_prev_q) ||
        (edge_blanking_control_q[`LOW_FALL_BIT] &&
         !gen_low_in && low_prev_q);

    blank_timer #(
        .CNT_W(BLANK_CNT_W)
    ) u_blank (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .start(blank_start),
        .load(blank_cycles(blanking_interval)),
        .blanking(blanking)
    );

    // Source selection and polarity
    assign limit_raw = src_pick(sync2_q, limit_source_select,
        limit_input_polarity);
    assign trip_raw = src_pick(sync2_q, trip_source_select,
        trip_input_polarity);

    // Blanking masks and enables
    assign limit_act = limit_raw && limit_function_enable &&
        !(edge_blanking_control_q[`LIM_BLANK_BIT] && blanking);
    assign trip_act = trip_raw && trip_mode_on &&
        !(edge_blanking_control_q[`TRIP_BLANK_BIT] && blanking);

    // Latched trip: set wins over the disable clear
    always_ff @(posedge clk) begin
        if (srst) begin
            trip_latched_q <= 1'b0;
        end else if (ce) begin
            if (trip_act && trip_response_mode == `TRIP_LATCHED) begin
                trip_latched_q <= 1'b1;
            end else if (!module_enable) begin
                trip_latched_q <= 1'b0;
            end
        end
    end

    // Cycle-by-cycle trip and limit: held until the next cycle starts
    always_ff @(posedge clk) begin
        if (srst) begin
            trip_cycle_q <= 1'b0;
            limit_cycle_q <= 1'b0;
        end else if (ce) begin
            if (trip_act && trip_response_mode == `TRIP_CYCLE) begin
                trip_cycle_q <= 1'b1;
            end else if (cycle_start) begin
                trip_cycle_q <= 1'b0;
            end
            if (limit_act) begin
                limit_cycle_q <= 1'b1;
            end else if (cycle_start) begin
                limit_cycle_q <= 1'b0;
            end
        end
    end

    // Trip outranks limit; a disabled function overrides nothing
    assign trip_on = trip_mode_on &&
        (trip_act || trip_latched_q || trip_cycle_q);
    assign limit_on = limit_function_enable &&
        (limit_act || limit_cycle_q);

    always_comb begin
        if (trip_on) begin
            drive_sel = DRIVE_TRIP;
        end else if (limit_on) begin
            drive_sel = DRIVE_LIMIT;
        end else begin
            drive_sel = DRIVE_PASS;
        end
    end

    // Registered generator outputs
    always_ff @(posedge clk) begin
        if (srst) begin
            gen_high_q <= 1'b0;
            gen_low_q <= 1'b0;
        end else if (ce) begin
            unique case (drive_sel)
                DRIVE_TRIP: begin
                    gen_high_q <= override_values_q[`TRIP_OVR_HIGH];
                    gen_low_q <= override_values_q[`TRIP_OVR_LOW];
                end
                DRIVE_LIMIT: begin
                    gen_high_q <= override_values_q[`LIM_OVR_HIGH];
                    gen_low_q <= override_values_q[`LIM_OVR_LOW];
                end
                DRIVE_PASS: begin
                    gen_high_q <= gen_high_in;
                    gen_low_q <= gen_low_in;
                end
            endcase
        end
    end

    // Trigger on the first cycle of a time base match
    assign trig_match = (trigger_compare_value_q != `RST_VAL) &&
        (time_base == trigger_compare_value_q);

    always_ff @(posedge clk) begin
        if (srst) begin
            match_prev_q <= 1'b0;
            trigger_q <= 1'b0;
        end else if (ce) begin
            match_prev_q <= trig_match;
            trigger_q <= trig_match && !match_prev_q;
        end
    end

    assign rdata = rdata_q;
    assign gen_high_output = gen_high_q;
    assign gen_low_output = gen_low_q;
    assign trigger_pulse = trigger_q;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_cycle_end;
        ce && cycle_start && !limit_act;
    endsequence

    sequence s_trip_force;
        ce && trip_on;
    endsequence

    chk_trip_latch_hold: assert property (
        ce && trip_latched_q && module_enable |=> trip_latched_q)
        else $error("latched trip lost while enabled");

    chk_trip_latch_set: assert property (
        ce && trip_act && trip_response_mode == `TRIP_LATCHED
        |=> trip_latched_q)
        else $error("latched trip not captured");

    chk_trip_output: assert property (
        s_trip_force |=> gen_high_output ==
            $past(override_values_q[`TRIP_OVR_HIGH]) &&
            gen_low_output == $past(override_values_q[`TRIP_OVR_LOW]))
        else $error("trip override values not driven");

    chk_limit_output: assert property (
        ce && !trip_on && limit_on |=> gen_high_output ==
            $past(override_values_q[`LIM_OVR_HIGH]) &&
            gen_low_output == $past(override_values_q[`LIM_OVR_LOW]))
        else $error("limit override values not driven");

    chk_limit_disabled: assert property (
        ce && !trip_on && !limit_function_enable
        |=> gen_high_output == $past(gen_high_in) &&
            gen_low_output == $past(gen_low_in))
        else $error("limit acted while disabled");

    chk_trip_ignored: assert property (
        ce && trip_response_mode == `TRIP_OFF && !limit_on
        |=> gen_high_output == $past(gen_high_in) &&
            gen_low_output == $past(gen_low_in))
        else $error("trip acted while disabled");

    chk_cycle_release: assert property (
        s_cycle_end |=> !limit_cycle_q)
        else $error("limit override outlived its cycle");

    chk_trig_zero: assert property (
        ce && trigger_compare_value_q == `RST_VAL |=> !trigger_pulse)
        else $error("trigger with zero compare value");

    chk_trig_match: assert property (
        ce && trig_match && !match_prev_q |=> trigger_pulse and
        (ce |=> !trigger_pulse))
        else $error("trigger pulse missing or too long");

    chk_trip_blank: assert property (
        blanking && edge_blanking_control_q[`TRIP_BLANK_BIT] |-> !trip_act)
        else $error("trip seen during blanking");

    chk_reserved_read: assert property (
        ce && reg_req.rd && reg_req.addr == `IDX_LIMIT_TRIP_CTRL
        |=> (rdata & ~`MASK_LIMIT_TRIP) == `READ_ZERO)
        else $error("unimplemented bits read nonzero");

endmodule

`default_nettype wire

// [logic/pwm_prot_regs.svh]
// Register indices, field positions, masks and timing of the protection block.
// Included by the protection block files; definitions only.
`ifndef PWM_PROT_REGS_SVH
`define PWM_PROT_REGS_SVH

// Register indices on the plain register port
`define IDX_LIMIT_TRIP_CTRL 3'h0
`define IDX_TRIG_CMP 3'h1
`define IDX_BLANK_CTRL 3'h2
`define IDX_OVERRIDE 3'h3
`define IDX_STATUS 3'h4

// Reset value and value of unmapped or unimplemented bits
`define RST_VAL 16'h0000
`define READ_ZERO 16'h0000

// Writable bits of each register
`define MASK_LIMIT_TRIP 16'h1FFF
`define MASK_TRIG 16'hFFF8
`define MASK_BLANK 16'hFFF8
`define MASK_OVERRIDE 16'h003C

// Limit and trip control fields
`define LIM_SRC_HI 12
`define LIM_SRC_LO 9
`define LIM_POL_BIT 8
`define LIM_EN_BIT 7
`define TRIP_SRC_HI 6
`define TRIP_SRC_LO 3
`define TRIP_POL_BIT 2
`define TRIP_MODE_HI 1
`define TRIP_MODE_LO 0

// Trip response modes
`define TRIP_LATCHED 2'h0
`define TRIP_CYCLE 2'h1
`define TRIP_OFF 2'h3

// Source selector codes
`define SRC_GRP_CMP 2'h0
`define SRC_GRP_SHARED 2'h2
`define SRC_OWN_TWO 4'hD
`define SRC_OWN_FOUR 4'hF

// Blanking control fields
`define HIGH_RISE_BIT 15
`define HIGH_FALL_BIT 14
`define LOW_RISE_BIT 13
`define LOW_FALL_BIT 12
`define TRIP_BLANK_BIT 11
`define LIM_BLANK_BIT 10
`define BLANK_HI 9
`define BLANK_LO 3

// Override value fields
`define TRIP_OVR_HIGH 5
`define TRIP_OVR_LOW 4
`define LIM_OVR_HIGH 3
`define LIM_OVR_LOW 2

// Status fields
`define ST_TRIP_LATCHED 0
`define ST_TRIP_CYCLE 1
`define ST_LIMIT_CYCLE 2
`define ST_BLANKING 3
`define ST_TRIP_ACTIVE 4
`define ST_LIMIT_ACTIVE 5

// Timing
`define CLK_PERIOD_NS 40
`define BLANK_STEP_NS 8

`endif

// [logic/pwm_prot_pkg.sv]
// Types shared by the PWM protection block files.
// No assumptions beyond a SystemVerilog compiler.
package pwm_prot_pkg;

    // Comparator and trip inputs of one generator
    typedef struct packed {
        logic [3:0] cmp;
        logic [3:0] shared;
        logic own_trip_two;
        logic own_trip_four;
    } trip_sources_t;

    // One register request
    typedef struct packed {
        logic [2:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    // What drives the generator outputs
    typedef enum logic [1:0] {DRIVE_PASS, DRIVE_LIMIT, DRIVE_TRIP} drive_sel_t;

endpackage

// [logic/blank_timer.sv]
// Leading-edge blanking down-counter.
// Assumes start pulses and load value synchronous to clk.
`timescale 1ns/1ps
`default_nettype none

module blank_timer #(
    parameter int CNT_W = 8
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic start,
    input wire logic [CNT_W-1:0] load,
    output logic blanking
);

    logic [CNT_W-1:0] count_q;

    // Reload on every enabled edge, else count down to zero
    always_ff @(posedge clk) begin
        if (srst) begin
            count_q <= '0;
        end else if (ce) begin
            if (start) begin
                count_q <= load;
            end else if (count_q != '0) begin
                count_q <= count_q - CNT_W'(1);
            end
        end
    end

    assign blanking = (count_q != '0);

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    chk_blank_reload: assert property (
        ce && start |=> count_q == $past(load))
        else $error("blanking counter not reloaded");

endmodule

`default_nettype wire

// [tb/trip_src_model.sv]
// Model of the comparators and trip pins that feed one protection block.
// Assumes selections and levels change just after a clock edge.
`timescale 1ns/1ps
`default_nettype none

module trip_src_model import pwm_prot_pkg::*; (
    input wire logic [3:0] lim_code,
    input wire logic lim_lvl,
    input wire logic [3:0] trip_code,
    input wire logic trip_lvl,
    input wire logic idle_lvl,
    output var trip_sources_t sources
);
    logic [9:0] lines;

    // Flat bit position of a selector code, -1 when it names no line
    function automatic int pos(input logic [3:0] c);
        if (c < 4'h4) begin
            return 6 + int'(c);
        end
        if (c >= 4'h8 && c < 4'hC) begin
            return 2 + int'(c) - 8;
        end
        if (c == 4'hD) begin
            return 1;
        end
        if (c == 4'hF) begin
            return 0;
        end
        return -1;
    endfunction

    // Unselected lines sit at the idle level, never at a stale value
    always_comb begin
        lines = {10{idle_lvl}};
        if (pos(lim_code) >= 0) begin
            lines[pos(lim_code)] = lim_lvl;
        end
        if (pos(trip_code) >= 0) begin
            lines[pos(trip_code)] = trip_lvl;
        end
    end

    assign sources = lines;
endmodule

`default_nettype wire

// [tb/pwm_fault_limit_trigger_blanking_bench.sv]
// Self-checking bench for the PWM protection, blanking and trigger block.
// Assumes the trip source model drives the comparator and trip lines.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_prot_regs.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
    $display("unexpected at %0t: got %h exp %h", $time, g, e); end end

module pwm_fault_limit_trigger_blanking_bench import pwm_prot_pkg::*;;
    logic clk = 0, srst = 1, ce = 1, hi_in = 0, lo_in = 0, cs = 0;
    logic men = 1, hi_o, lo_o, trg, pol, llvl = 0, tlvl = 0, idle = 0;
    reg_req_t req = '0;
    trip_sources_t src;
    logic [15:0] rdata, tb = 16'h0000, d, t, o1, o2;
    logic [3:0] lcode = 4'h0, tcode = 4'h0;
    logic [1:0] exp, pre, post;
    int checks = 0, miscompares = 0, cycles = 0;
    integer seed = 32'h16f7;

    // Clock and the device under test with its far side
    always #20 clk = ~clk;
    pwm_prot #(.BLANK_CNT_W(8), .TB_W(16)) i_dut (.clk(clk), .srst(srst),
        .ce(ce), .reg_req(req), .rdata(rdata), .sources(src),
        .gen_high_in(hi_in), .gen_low_in(lo_in), .time_base(tb),
        .cycle_start(cs), .module_enable(men), .gen_high_output(hi_o),
        .gen_low_output(lo_o), .trigger_pulse(trg));
    trip_src_model i_src (.lim_code(lcode), .lim_lvl(llvl),
        .trip_code(tcode), .trip_lvl(tlvl), .idle_lvl(idle),
        .sources(src));

    // Ends the run with the counts and the verdict
    task automatic print_verdict;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Cuts a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            print_verdict;
        end
    end

    // Register port cycles, one strobe cycle each
    task automatic wr(input logic [2:0] a, input logic [15:0] v);
        @(posedge clk) req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk) req <= '0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [15:0] m, e);
        @(posedge clk) req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk) req <= '0;
        #1 `CHK(rdata & m, e)
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic outs(input logic [1:0] e);
        #1 `CHK({hi_o, lo_o}, e)
    endtask
    task automatic pulse_cs;
        @(posedge clk) cs <= 1'b1;
        @(posedge clk) cs <= 1'b0;
    endtask
    task automatic lvl(input logic v);
        @(posedge clk) begin
            llvl <= v;
            tlvl <= v;
        end
    endtask
    task automatic step(input logic [15:0] v);
        @(posedge clk) tb <= v;
        o2 = o1;
        o1 = tb;
        #1 `CHK(trg, t != 16'h0000 && o1 == t && o2 != t)
    endtask

    // Expected register contents and selector validity
    function automatic logic [15:0] wmask(input int i);
        case (i)
            0: return `MASK_LIMIT_TRIP;
            1: return `MASK_TRIG;
            2: return `MASK_BLANK;
            3: return `MASK_OVERRIDE;
            default: return `READ_ZERO;
        endcase
    endfunction
    function automatic logic valid_code(input logic [3:0] c);
        return c < 4'h4 || (c >= 4'h8 && c < 4'hC) || c == 4'hD || c == 4'hF;
    endfunction

    // Main sequence
    initial begin
        cyc(2);
        srst <= 1'b0;
        wr(3'h4, 16'hFFFF);
        for (int a = 0; a < 8; a++) begin
            rd(a[2:0], 16'hFFFF, `RST_VAL);
        end
        for (int i = 0; i < 8; i++) begin
            d = $random(seed);
            wr(i[2:0], d);
            rd(i[2:0], i == 4 ? 16'h0000 : 16'hFFFF, d & wmask(i));
        end
        wr(3'h0, 16'h0003);
        wr(3'h1, 16'h0000);
        wr(3'h2, 16'h0000);
        @(posedge clk) men <= 1'b0;
        @(posedge clk) men <= 1'b1;
        // Every selector code on both paths, random polarity
        for (int c = 0; c < 16; c++) begin
            for (int w = 0; w < 2; w++) begin
                pol = $random(seed);
                exp = valid_code(c[3:0]) ? 2'b10 : 2'b00;
                @(posedge clk) begin
                    lcode <= c[3:0];
                    tcode <= c[3:0];
                    llvl <= pol;
                    tlvl <= pol;
                    idle <= valid_code(c[3:0]) ? pol : ~pol;
                end
                wr(3'h0, w ? {3'h0, c[3:0], pol, 1'b1, 7'h03}
                           : {3'h0, 4'h0, 2'b00, c[3:0], pol, 2'h1});
                wr(3'h3, w ? 16'h0008 : 16'h0020);
                pulse_cs;
                cyc(3);
                outs(2'b00);
                lvl(~pol);
                cyc(4);
                outs(exp);
                lvl(pol);
                cyc(4);
                outs(exp);
                pulse_cs;
                cyc(4);
                outs(2'b00);
            end
        end
        // Response modes, limit enable and priority
        @(posedge clk) begin
            lcode <= 4'h0;
            tcode <= 4'h0;
            idle <= 1'b0;
            llvl <= 1'b0;
            tlvl <= 1'b0;
        end
        wr(3'h3, 16'h0024);
        wr(3'h0, 16'h0000);
        pulse_cs;
        lvl(1'b1);
        cyc(4);
        outs(2'b10);
        rd(3'h4, 16'h0001, 16'h0001);
        lvl(1'b0);
        pulse_cs;
        cyc(4);
        outs(2'b10);
        @(posedge clk) men <= 1'b0;
        @(posedge clk) men <= 1'b1;
        cyc(2);
        outs(2'b00);
        for (int m = 2; m < 4; m++) begin
            wr(3'h0, 16'(m));
            lvl(1'b1);
            cyc(4);
            outs(2'b00);
            lvl(1'b0);
        end
        wr(3'h0, 16'h0003);
        lvl(1'b1);
        cyc(4);
        outs(2'b00);
        wr(3'h0, 16'h0083);
        cyc(4);
        outs(2'b01);
        wr(3'h0, 16'h0081);
        cyc(4);
        outs(2'b10);
        lvl(1'b0);
        cyc(2);
        pulse_cs;
        cyc(4);
        outs(2'b00);
        // Each blanking edge, enabled alone or left out, on both paths
        @(posedge clk) begin
            lcode <= 4'h1;
            tcode <= 4'h1;
        end
        for (int e = 0; e < 4; e++) begin
            for (int w = 0; w < 2; w++) begin
                for (int n = 0; n < 2; n++) begin
                    post = e[1] ? {1'b0, ~e[0]} : {~e[0], 1'b0};
                    pre = e[1] ? {1'b0, e[0]} : {e[0], 1'b0};
                    d = 16'h8000 >> e;
                    @(posedge clk) {hi_in, lo_in} <= pre;
                    wr(3'h2, 16'h0000);
                    wr(3'h0, w ? 16'h0283 : 16'h0009);
                    wr(3'h3, w ? {12'h000, ~post, 2'b00}
                               : {10'h000, ~post, 4'h0});
                    pulse_cs;
                    cyc(2);
                    wr(3'h2, (n ? 16'hF000 & ~d : d) | 16'h0140 |
                        (w ? 16'h0400 : 16'h0800));
                    @(posedge clk) begin
                        {hi_in, lo_in} <= post;
                        llvl <= 1'b1;
                        tlvl <= 1'b1;
                    end
                    cyc(4);
                    outs(n ? ~post : post);
                    cyc(12);
                    outs(~post);
                    lvl(1'b0);
                    pulse_cs;
                    cyc(3);
                end
            end
        end
        wr(3'h2, 16'h0000);
        // Trigger matches at the ends of the range and at random
        for (int r = 0; r < 6; r++) begin
            d = $random(seed);
            t = r == 0 ? 16'h0008 : r == 1 ? 16'hFFF8
                : (d & 16'hFFF8) | 16'h0008;
            wr(3'h1, t);
            o1 = tb;
            step(t - 16'h0010);
            step(t - 16'h0008);
            repeat (3) step(t);
            repeat (2) step(t + 16'h0008);
        end
        wr(3'h1, 16'h0007);
        t = 16'h0000;
        o1 = tb;
        repeat (3) step(16'h0000);
        print_verdict;
    end
endmodule

`default_nettype wire
